/* File: design/hpge_pkg.sv */
// package: register map, field positions and reset values of the global event/mask block
`default_nettype none
package hpge_pkg;
  localparam logic [7:0] OFF_GLOBAL_EVENT_MASK_CONTROL = 8'h20;
  localparam logic [7:0] OFF_SLOT_FIRST = 8'h24;
  localparam logic [7:0] OFF_SLOT_LAST = 8'h38;
  localparam logic [7:0] OFF_COMMAND = 8'h14;
  localparam logic [7:0] OFF_COMMAND_STATE = 8'h16;
  localparam logic [7:0] OFF_PENDING = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h44;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h48;
  localparam logic [7:0] OFF_ERR_ENABLE = 8'h4c;
  localparam int BIT_ARB_TIMEOUT = 17;
  localparam int BIT_CMD_DONE = 16;
  localparam int BIT_ARB_ERR_MASK = 3;
  localparam int BIT_CMD_IRQ_MASK = 2;
  localparam int BIT_GLOBAL_ERR_MASK = 1;
  localparam int BIT_GLOBAL_IRQ_MASK = 0;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam int SLOT_COUNT = 6;
  localparam int CMD_EXEC_CYCLES = 8;
  localparam logic [31:0] SLOT_STATUS_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: design/sticky_flag.sv */
// sticky event bit with write-one-to-clear, set wins over clear
`default_nettype none
module sticky_flag (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clear)
      flag <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: design/wb_decode.sv */
// classic wishbone single-cycle handshake: one ack per request
`default_nettype none
module wb_decode (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cyc,
  input wire logic stb,
  output logic ack,
  output logic take
);
  assign take = cyc && stb && !ack;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= take;
  end
endmodule
`default_nettype wire

/* File: design/hotplug_global_event_mask.sv */
// global event latches, masks, error message, slot registers and wishbone slave
//
// Register access over Wishbone is this design's own decision.
`default_nettype none
// Summary of operation
// [R1] An arbiter timeout sets the bit-17 flag, which resets to zero and clears only on a written one.
// [R2] The busy bit falling from one to zero sets the bit-16 flag, which is write-one-to-clear.
// [R3] The bit-3 mask, set after reset, blocks arbiter errors but never stops the flag being set.
// [R4] With both error masks clear and a reporting enable set, a timeout sends a non-fatal message.
// [R5] The bit-2 mask, set after reset, blocks command-done interrupts on system_irq but not the flag or irq_status.
// [R6] The bit-1 mask, set after reset, blocks every system error from the controller.
// [R7] The bit-0 mask, set after reset, blocks system interrupts and leaves the pending bits alone.
// [R8] The wake output ignores the global interrupt mask.
// [R9] Six slot registers each hold status in 15:0, event latch in 23:16 and masks in 31:24.
// [R10] Slot registers report status, configure slot interrupts, and show events.
// [R11] Command-done pending reads one exactly when the flag is set and its mask is clear.
// [R12] Arbiter pending reads one exactly when the flag is set and its mask is clear.
// [R13] The busy bit rises on a command write and falls when execution finishes, never otherwise.
// [R14] The system interrupt is high while command-done pending or an unmasked slot event is set and the global mask is clear.
module hotplug_global_event_mask (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic err_o,
  input wire logic arbiter_timeout,
  input wire logic serr_enable,
  input wire logic nonfatal_enable,
  input wire logic wake_event,
  input wire logic [15:0] slot_status_in [hpge_pkg::SLOT_COUNT],
  input wire logic [7:0] slot_event_in [hpge_pkg::SLOT_COUNT],
  output logic err_nonfatal_msg,
  output logic system_irq,
  output logic wake_out,
  output logic irq
);
  import hpge_pkg::*;

  typedef enum logic [0:0] {
    CMD_IDLE = 1'b0,
    CMD_RUN = 1'b1
  } cmd_state_e;

  cmd_state_e cmd_state;
  logic take;
  logic wr;
  logic rd_hit;
  logic controller_busy_flag;
  logic busy_q;
  logic [7:0] exec_count;
  logic [7:0] command_code;
  logic arbiter_timeout_flag;
  logic command_done_flag;
  logic arbiter_error_mask;
  logic command_done_irq_mask;
  logic global_error_mask;
  logic global_irq_mask;
  logic command_done_pending;
  logic arbiter_error_pending;
  logic cmd_done_event;
  logic w1c_main;
  logic [7:0] slot_latch [SLOT_COUNT];
  logic [7:0] slot_mask [SLOT_COUNT];
  logic [15:0] slot_status [SLOT_COUNT];
  logic [2:0] slot_idx;
  logic slot_hit;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [3:0] irq_event;
  logic err_enable;
  logic [31:0] next_dat;

  wb_decode u_wb (
    .clock(clock),
    .rst_n(rst_n),
    .cyc(cyc_i),
    .stb(stb_i),
    .ack(ack_o),
    .take(take)
  );

  assign wr = take && we_i;
  assign err_o = 1'b0;
  assign slot_idx = 3'((adr_i - OFF_SLOT_FIRST) >> 2);
  assign slot_hit = (adr_i >= OFF_SLOT_FIRST) && (adr_i <= OFF_SLOT_LAST) && (adr_i[1:0] == 2'b00);
  assign w1c_main = wr && (adr_i == OFF_GLOBAL_EVENT_MASK_CONTROL) && sel_i[2];

  // command engine: a fixed execution time stands in for the slot sequencer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmd_state <= CMD_IDLE;
      exec_count <= 8'h00;
      command_code <= 8'h00;
    end
    else
    begin
      case (cmd_state)
        CMD_IDLE:
        begin
          // writes while busy are ignored, so only idle accepts a code
          if (wr && adr_i == OFF_COMMAND && sel_i[0])
          begin
            command_code <= dat_i[7:0];
            exec_count <= 8'(CMD_EXEC_CYCLES - 1);
            cmd_state <= CMD_RUN; // [R13]
          end
        end
        CMD_RUN:
        begin
          if (exec_count == 8'h00)
            cmd_state <= CMD_IDLE; // [R13]
          else
            exec_count <= exec_count - 8'h01;
        end
        default:
          cmd_state <= CMD_IDLE;
      endcase
    end
  end

  assign controller_busy_flag = (cmd_state == CMD_RUN);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      busy_q <= 1'b0;
    else
      busy_q <= controller_busy_flag;
  end

  assign cmd_done_event = busy_q && !controller_busy_flag; // [R2]

  sticky_flag u_arb_flag (
    .clock(clock),
    .rst_n(rst_n),
    .set(arbiter_timeout), // [R1] [R3]
    .clear(w1c_main && dat_i[BIT_ARB_TIMEOUT]),
    .flag(arbiter_timeout_flag)
  );

  sticky_flag u_done_flag (
    .clock(clock),
    .rst_n(rst_n),
    .set(cmd_done_event), // [R2] [R5]
    .clear(w1c_main && dat_i[BIT_CMD_DONE]),
    .flag(command_done_flag)
  );

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      arbiter_error_mask <= MASK_RESET[BIT_ARB_ERR_MASK];
      command_done_irq_mask <= MASK_RESET[BIT_CMD_IRQ_MASK];
      global_error_mask <= MASK_RESET[BIT_GLOBAL_ERR_MASK];
      global_irq_mask <= MASK_RESET[BIT_GLOBAL_IRQ_MASK];
    end
    else if (wr && adr_i == OFF_GLOBAL_EVENT_MASK_CONTROL && sel_i[0])
    begin
      arbiter_error_mask <= dat_i[BIT_ARB_ERR_MASK];
      command_done_irq_mask <= dat_i[BIT_CMD_IRQ_MASK];
      global_error_mask <= dat_i[BIT_GLOBAL_ERR_MASK];
      global_irq_mask <= dat_i[BIT_GLOBAL_IRQ_MASK];
    end
  end

  assign command_done_pending = command_done_flag && !command_done_irq_mask; // [R11]
  assign arbiter_error_pending = arbiter_timeout_flag && !arbiter_error_mask; // [R12]

  // one message per cycle the timeout input is high, not per cycle the flag stays set
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      err_nonfatal_msg <= 1'b0;
    else
      err_nonfatal_msg <= arbiter_timeout && !arbiter_error_mask && !global_error_mask
        && (serr_enable || nonfatal_enable); // [R4] [R6]
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      system_irq <= 1'b0;
    else
      system_irq <= !global_irq_mask && (command_done_pending || slot_irq_any()); // [R7] [R14]
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wake_out <= 1'b0;
    else
      wake_out <= wake_event; // [R8]
  end

  function automatic logic slot_irq_any();
    logic any;
    any = 1'b0;
    for (int i = 0; i < SLOT_COUNT; i++)
      any = any || ((slot_latch[i] & ~slot_mask[i]) != 8'h00);
    return any;
  endfunction

  // slot registers: status sampled, latches write-one-to-clear, masks writable
  for (genvar s = 0; s < SLOT_COUNT; s++)
  begin : g_slot
    always_ff @(posedge clock)
    begin
      if (!rst_n)
      begin
        slot_status[s] <= SLOT_STATUS_RESET[15:0];
        slot_latch[s] <= 8'h00;
        slot_mask[s] <= 8'hff;
      end
      else
      begin
        slot_status[s] <= slot_status_in[s]; // [R9] [R10]
        if (wr && slot_hit && slot_idx == 3'(s))
        begin
          slot_latch[s] <= (slot_latch[s] & ~(sel_i[2] ? dat_i[23:16] : 8'h00))
            | slot_event_in[s]; // [R10]
          if (sel_i[3])
            slot_mask[s] <= dat_i[31:24]; // [R10]
        end
        else
          slot_latch[s] <= slot_latch[s] | slot_event_in[s];
      end
    end
  end

  // generic interrupt block: status sticky, clear by write-one, level output
  assign irq_event = {wake_event, |err_nonfatal_msg, cmd_done_event, arbiter_timeout};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_status <= 4'h0;
      irq_enable <= 4'h0;
      err_enable <= 1'b0;
    end
    else
    begin
      irq_status <= irq_event | (irq_status &
        ~((wr && adr_i == OFF_IRQ_CLEAR && sel_i[0]) ? dat_i[3:0] : 4'h0));
      if (wr && adr_i == OFF_IRQ_ENABLE && sel_i[0])
        irq_enable <= dat_i[3:0];
      if (wr && adr_i == OFF_ERR_ENABLE && sel_i[0])
        err_enable <= dat_i[0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  always_comb
  begin
    next_dat = 32'h0000_0000;
    if (slot_hit && slot_idx < 3'(SLOT_COUNT))
      next_dat = {slot_mask[slot_idx], slot_latch[slot_idx], slot_status[slot_idx]}; // [R9]
    else
    begin
      case (adr_i)
        OFF_GLOBAL_EVENT_MASK_CONTROL:
          next_dat = {14'h0000, arbiter_timeout_flag, command_done_flag, 12'h000,
            arbiter_error_mask, command_done_irq_mask, global_error_mask, global_irq_mask};
        OFF_COMMAND:
          next_dat = {15'h0, controller_busy_flag, 8'h00, command_code};
        OFF_PENDING:
          next_dat = {30'h0000_0000, arbiter_error_pending, command_done_pending};
        OFF_IRQ_STATUS:
          next_dat = {28'h000_0000, irq_status};
        OFF_IRQ_ENABLE:
          next_dat = {28'h000_0000, irq_enable};
        OFF_ERR_ENABLE:
          next_dat = {31'h0000_0000, err_enable};
        default:
          next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      dat_o <= 32'h0000_0000;
    else if (take && !we_i)
      dat_o <= next_dat;
  end

  a_arb_flag_set: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    arbiter_timeout |=> arbiter_timeout_flag) else $error("arbiter flag not set");
  a_done_flag_set: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    $fell(controller_busy_flag) |-> ##1 command_done_flag) else $error("done flag missing");
  a_arb_mask_err: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    arbiter_error_mask |=> !err_nonfatal_msg) else $error("masked error sent");
  a_nonfatal_sent: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    (arbiter_timeout && !arbiter_error_mask && !global_error_mask && serr_enable)
    |=> err_nonfatal_msg) else $error("nonfatal message missing");
  a_global_err: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
    global_error_mask |=> !err_nonfatal_msg) else $error("global mask ignored");
  a_irq_masked: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    global_irq_mask |=> !system_irq) else $error("irq despite mask");
  a_irq_raise: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
    (command_done_pending && !global_irq_mask) |=> system_irq) else $error("irq not raised");
  a_pending_eq: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
    command_done_pending == (command_done_flag && !command_done_irq_mask))
    else $error("pending mismatch");
  a_busy_cause: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
    $rose(controller_busy_flag) |-> $past(wr) && $past(adr_i) == OFF_COMMAND)
    else $error("busy without command");
  a_busy_len: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
    $rose(controller_busy_flag) |-> controller_busy_flag [*8] ##1 !controller_busy_flag)
    else $error("busy length wrong");
endmodule
`default_nettype wire

/* File: dv/upstream_model.sv */
// upstream link and arbiter stand-in: raises timeouts, counts error messages
`default_nettype none
module upstream_model (
  input wire logic clock,
  input wire logic fire,
  input wire logic err_nonfatal_msg,
  output var logic arbiter_timeout,
  output var int msg_count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial arbiter_timeout = 1'b0;
  initial msg_count = 0;
  // one-cycle timeout per request from the bench
  always @(posedge clock)
  begin
    arbiter_timeout <= fire;
  end
  always @(posedge clock)
  begin
    if (err_nonfatal_msg === 1'b1)
      msg_count <= msg_count + 1;
  end
endmodule
`default_nettype wire

/* File: dv/hotplug_global_event_mask_bench.sv */
// self-checking bench of the global event and mask block
`default_nettype none
module hotplug_global_event_mask_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hpge_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic serr_enable = 1'b0;
  logic nonfatal_enable = 1'b0;
  logic wake_event = 1'b0;
  logic fire = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_o;
  logic ack_o, err_o, arbiter_timeout, err_nonfatal_msg, system_irq, wake_out, irq;
  logic [15:0] slot_status [SLOT_COUNT];
  logic [7:0] slot_event [SLOT_COUNT];
  logic [31:0] expect_q [$];
  logic [15:0] seed = 16'h6c35;
  int err_count = 0;
  int n_checks = 0;
  int msg_count;
  int m0;

  always #10 clock = ~clock;

  hotplug_global_event_mask u_dut (.clock(clock), .rst_n(rst_n), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .arbiter_timeout(arbiter_timeout),
    .serr_enable(serr_enable), .nonfatal_enable(nonfatal_enable),
    .wake_event(wake_event), .slot_status_in(slot_status), .slot_event_in(slot_event),
    .err_nonfatal_msg(err_nonfatal_msg), .system_irq(system_irq),
    .wake_out(wake_out), .irq(irq));

  upstream_model u_up (.clock(clock), .fire(fire), .err_nonfatal_msg(err_nonfatal_msg),
    .arbiter_timeout(arbiter_timeout), .msg_count(msg_count));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic conclude;
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until the edge that samples ack, then released
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge clock);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= s;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (ack_o === 1'b1)
        break;
    end
    if (n == 20)
    begin
      err_count++;
      conclude();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expect_q.push_back(exp);
    bus(a, 1'b0, 32'h0000_0000, 4'hf);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(a, 1'b1, d, s);
  endtask

  task automatic pulse;
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // read data is judged at the edge that carries ack
  always @(posedge clock)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0 && expect_q.size() > 0)
      check(dat_o, expect_q.pop_front());
  end

  initial
  begin
    #400000;
    err_count++;
    conclude();
  end

  initial
  begin
    for (int i = 0; i < SLOT_COUNT; i++)
    begin
      slot_status[i] = 16'h0000;
      slot_event[i] = 8'h00;
    end
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    serr_enable <= 1'b1;
    rd(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0000_000f);
    pulse();
    wr(OFF_COMMAND, 32'h0000_0001, 4'h1);
    wr(OFF_COMMAND, 32'h0000_0002, 4'h1);
    rd(OFF_COMMAND, 32'h0001_0001);
    check(msg_count, 0);
    repeat (12) @(posedge clock);
    rd(OFF_COMMAND, 32'h0000_0001);
    rd(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0003_000f);
    rd(OFF_PENDING, 32'h0000_0000);
    check(system_irq, 0);
    wr(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0000_0000, 4'h1);
    rd(OFF_PENDING, 32'h0000_0003);
    repeat (2) @(posedge clock);
    check(system_irq, 1);
    wr(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0000_0001, 4'h1);
    rd(OFF_PENDING, 32'h0000_0003);
    repeat (2) @(posedge clock);
    check(system_irq, 0);
    wake_event <= 1'b1;
    repeat (2) @(posedge clock);
    check(wake_out, 1);
    wake_event <= 1'b0;
    // done flag still set, global mask open: only the command mask can hold the irq low
    wr(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0000_0004, 4'h1);
    repeat (2) @(posedge clock);
    check(system_irq, 0);
    wr(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0001_0000, 4'h4);
    rd(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0002_0004);
    wr(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0002_0000, 4'h4);
    rd(OFF_GLOBAL_EVENT_MASK_CONTROL, 32'h0000_0004);
    m0 = msg_count;
    // enables and masks: serr only, nonfatal only, neither, arbiter mask, global mask
    for (int k = 0; k < 5; k++)
    begin
      serr_enable <= (k == 0);
      nonfatal_enable <= (k != 0 && k != 2);
      wr(OFF_GLOBAL_EVENT_MASK_CONTROL, (k == 3) ? 32'h9 : (k == 4) ? 32'h3 : 32'h1, 4'h1);
      pulse();
      check(msg_count, m0 + ((k < 2) ? k + 1 : 2));
    end
    rd(OFF_IRQ_STATUS, 32'h0000_000f);
    wr(OFF_IRQ_CLEAR, 32'h0000_000f, 4'h1);
    check(irq, 0);
    wr(OFF_IRQ_ENABLE, 32'h0000_0001, 4'h1);
    pulse();
    rd(OFF_IRQ_STATUS, 32'h0000_0001);
    check(irq, 1);
    wr(OFF_IRQ_ENABLE, 32'h0000_0000, 4'h1);
    check(irq, 0);
    wr(OFF_IRQ_ENABLE, 32'h0000_0001, 4'h1);
    wr(OFF_IRQ_CLEAR, 32'h0000_0001, 4'h1);
    check(irq, 0);
    for (int i = 0; i < SLOT_COUNT; i++)
    begin
      seed = lfsr(seed);
      slot_status[i] <= seed;
    end
    slot_event[2] <= 8'h01;
    @(posedge clock);
    slot_event[2] <= 8'h00;
    repeat (3) @(posedge clock);
    for (int i = 0; i < SLOT_COUNT; i++)
      rd(OFF_SLOT_FIRST + 8'(4 * i), {8'hff, (i == 2) ? 8'h01 : 8'h00, slot_status[i]});
    wr(OFF_SLOT_FIRST + 8'h08, 32'h0001_0000, 4'h4);
    rd(OFF_SLOT_FIRST + 8'h08, {16'hff00, slot_status[2]});
    rd(8'h80, 32'h0000_0000);
    wr(OFF_ERR_ENABLE, 32'h0000_0001, 4'h1);
    rd(OFF_ERR_ENABLE, 32'h0000_0001);
    check(err_o, 0);
    repeat (2) @(posedge clock);
    conclude();
  end
endmodule
`default_nettype wire
